// [inc/ictm_pkg.sv]
//==========================================================================
package ictm_pkg;

    //======================================================================
    // host register map (byte addresses, quadlet aligned)
    localparam logic [7:0]  ICTM_REG_CTRL       = 8'h08;
    localparam logic [7:0]  ICTM_REG_FLAGS      = 8'h0C;
    localparam logic [7:0]  ICTM_REG_CYCLE_TIME = 8'h14;
    // serial-bus register space location of the same timer
    localparam logic [11:0] ICTM_CSR_CYCLE_TIME = 12'h200;

    //======================================================================
    // control register fields
    localparam int          ICTM_CTRL_TIMER_EN  = 0;
    localparam int          ICTM_CTRL_MASTER    = 1;
    localparam int          ICTM_CTRL_TSEL      = 2;
    localparam logic [2:0]  ICTM_CTRL_RESET     = 3'h0;

    // flag register fields, write one to clear
    localparam int          ICTM_FLG_STARTED    = 0;
    localparam int          ICTM_FLG_LOST       = 1;
    localparam int          ICTM_FLG_DONE       = 2;
    localparam logic [2:0]  ICTM_FLG_RESET      = 3'h0;

    //======================================================================
    // cycle time fields
    localparam int          ICTM_OFS_LSB        = 0;
    localparam int          ICTM_OFS_W          = 12;
    localparam int          ICTM_CNT_LSB        = 12;
    localparam int          ICTM_CNT_W          = 13;
    localparam int          ICTM_SEC_LSB        = 25;
    localparam int          ICTM_SEC_W          = 7;
    localparam logic [11:0] ICTM_OFS_LAST       = 12'hBFF;  // 3072 - 1
    localparam logic [12:0] ICTM_CNT_LAST       = 13'h1F3F; // 8000 - 1
    localparam logic [31:0] ICTM_TIME_RESET     = 32'h0000_0000;

    //======================================================================
    // timing
    localparam real         ICTM_CORE_MHZ       = 200.0;
    localparam real         ICTM_SCLK_MHZ       = 49.152;
    localparam int          ICTM_SCLK_DIV       = 2;
    localparam int          ICTM_SYNC_W         = 44;

endpackage

// [hw/ictm_sync2.sv]
`timescale 1ns/10ps
//==========================================================================
// two-stage synchroniser for pin inputs
module ictm_sync2
    import ictm_pkg::*;
#(
    parameter int W = ICTM_SYNC_W
) (
    input  wire logic         core_clk,  // core clock
    input  wire logic         reset_n,   // synchronous reset
    input  wire logic         core_ce,   // clock enable
    input  wire logic [W-1:0] async_in,  // raw pin levels
    input  wire logic [W-1:0] rst_val,   // idle level of each pin
    output logic      [W-1:0] sync_out   // synchronised levels
);

    logic [W-1:0] meta_ff;

    // reset value is constant per instance, so loaded by a clocked reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            meta_ff  <= rst_val;
            sync_out <= rst_val;
        end else if (core_ce) begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

// [hw/ictm_cycle_timer.sv]
`timescale 1ns/10ps
//==========================================================================
// cycle timer and cycle monitor
module ictm_cycle_timer
    import ictm_pkg::*;
(
    input  wire logic        core_clk,           // 200 MHz core clock
    input  wire logic        reset_n,            // synchronous reset
    input  wire logic        core_ce,            // clock enable
    // host port pins
    input  wire logic        host_cs_n,          // access strobe
    input  wire logic        host_wr_n,          // low: write
    input  wire logic [7:0]  host_addr,          // byte address
    input  wire logic [31:0] host_data_in,       // data pins, input
    output logic      [31:0] host_data_out,      // data pins, output
    output logic             host_data_oe,       // data pins, drive
    output logic             host_ack_n,         // access complete
    // timebase pins
    input  wire logic        phy_sclk,           // 49.152 MHz phy clock
    input  wire logic        ext_cycle_tick_in,  // external 8 kHz input
    output logic             cycle_tick_out,     // one-cycle tick pulse
    // receiver side
    input  wire logic        rx_cyc_start_valid, // cycle-start received
    input  wire logic [31:0] rx_cyc_start_data,  // its timer quadlet
    input  wire logic        iso_cycle_end,      // isochronous cycle over
    input  wire logic        csr_rd_req,         // serial-bus quadlet read
    input  wire logic [11:0] csr_rd_addr,        // its register offset
    output logic             csr_rd_valid,       // read answer strobe
    output logic             csr_rd_hit,         // offset was the timer
    output logic      [31:0] csr_rd_data,        // read answer data
    // transmitter side
    output logic             tx_cyc_start_req,   // send a cycle-start
    output logic      [31:0] tx_cyc_start_data,  // its timer quadlet
    input  wire logic        tx_cyc_start_sent,  // cycle-start went out
    // status levels
    output logic             cycle_started_flag, // cycle-started flag
    output logic             cycle_lost_flag,    // cycle-lost flag
    output logic             cycle_done_flag     // cycle-done flag
);

    //======================================================================
    // synchronised pins
    logic [ICTM_SYNC_W-1:0] sync_in;
    logic [ICTM_SYNC_W-1:0] sync_idle;
    logic [ICTM_SYNC_W-1:0] sync_out;
    logic                   cs_n_s;
    logic                   wr_n_s;
    logic [7:0]             addr_s;
    logic [31:0]            wdata_s;
    logic                   sclk_s;
    logic                   ext_s;

    assign sync_in   = {host_cs_n, host_wr_n, host_addr, host_data_in,
                        phy_sclk, ext_cycle_tick_in};
    assign sync_idle = {2'h3, 8'h00, 32'h0000_0000, 2'h1};
    assign {cs_n_s, wr_n_s, addr_s, wdata_s, sclk_s, ext_s} = sync_out;

    ictm_sync2 #(
        .W        (ICTM_SYNC_W)
    ) u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .core_ce  (core_ce),
        .async_in (sync_in),
        .rst_val  (sync_idle),
        .sync_out (sync_out)
    );

    //======================================================================
    // registers
    typedef enum logic {ICTM_IDLE, ICTM_HOLD} ictm_host_e;

    ictm_host_e  host_st_ff;
    logic [2:0]  ctrl_ff;
    logic [31:0] timer_ff;
    logic [31:0] nxt_timer;
    logic        nxt_tick;
    logic        sclk_d_ff;
    logic        ext_d_ff;
    logic        div_ff;
    logic        expect_ff;
    logic        in_cycle_ff;

    logic        timer_en;
    logic        is_master;
    logic        tsel;
    logic        tick24;
    logic        ext_rise;
    logic        host_acc;
    logic        host_wr;
    logic        wr_timer;
    logic        rx_load;
    logic        started_ev;
    logic        lost_ev;
    logic        done_ev;
    logic [2:0]  flg_set;
    logic [2:0]  flg_clr;

    assign timer_en  = ctrl_ff[ICTM_CTRL_TIMER_EN];
    assign is_master = ctrl_ff[ICTM_CTRL_MASTER];
    assign tsel      = ctrl_ff[ICTM_CTRL_TSEL];

    //======================================================================
    // 24.576 MHz tick: every second rising edge of the phy clock
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sclk_d_ff <= 1'b0;
            ext_d_ff  <= 1'b1;
            div_ff    <= 1'b0;
        end else if (core_ce) begin
            sclk_d_ff <= sclk_s;
            ext_d_ff  <= ext_s;
            if (sclk_s && !sclk_d_ff) begin
                div_ff <= ~div_ff;
            end
        end
    end

    assign tick24   = sclk_s && !sclk_d_ff && div_ff;
    // idle-high input only ever rises when really used as timebase
    assign ext_rise = ext_s && !ext_d_ff;

    //======================================================================
    // cycle count with carry into seconds
    function automatic logic [19:0] bump_cycle(
        input logic [12:0] cnt,
        input logic [6:0]  sec
    );
        logic [19:0] res;
        res = {sec, cnt};
        if (cnt == ICTM_CNT_LAST) begin
            res[12:0]  = 13'h0000;
            res[19:13] = sec + 7'h01;
        end else begin
            res[12:0] = cnt + 13'h0001;
        end
        return res;
    endfunction

    //======================================================================
    // timer next value
    always_comb begin
        logic [11:0] ofs;
        logic [12:0] cnt;
        logic [6:0]  sec;
        ofs       = timer_ff[ICTM_OFS_LSB +: ICTM_OFS_W];
        cnt       = timer_ff[ICTM_CNT_LSB +: ICTM_CNT_W];
        sec       = timer_ff[ICTM_SEC_LSB +: ICTM_SEC_W];
        nxt_timer = timer_ff;
        nxt_tick  = 1'b0;
        if (wr_timer) begin
            nxt_timer = wdata_s;
        end else if (rx_load) begin
            nxt_timer = rx_cyc_start_data;
        end else if (timer_en) begin
            if (tsel && ext_rise) begin
                nxt_timer = {bump_cycle(cnt, sec), 12'h000};
                nxt_tick  = 1'b1;
            end else if (tick24) begin
                if (ofs == ICTM_OFS_LAST) begin
                    nxt_timer[ICTM_OFS_LSB +: ICTM_OFS_W] = 12'h000;
                    // external mode: offset wraps, only the pin advances
                    if (!tsel) begin
                        nxt_timer[31:12] = bump_cycle(cnt, sec);
                        nxt_tick         = 1'b1;
                    end
                end else begin
                    nxt_timer[ICTM_OFS_LSB +: ICTM_OFS_W] = ofs + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            timer_ff       <= ICTM_TIME_RESET;
            cycle_tick_out <= 1'b0;
        end else if (core_ce) begin
            timer_ff       <= nxt_timer;
            cycle_tick_out <= nxt_tick;
        end
    end

    //======================================================================
    // cycle-start transmit request
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tx_cyc_start_req  <= 1'b0;
            tx_cyc_start_data <= ICTM_TIME_RESET;
        end else if (core_ce) begin
            tx_cyc_start_req <= nxt_tick && is_master;
            if (nxt_tick && is_master) begin
                tx_cyc_start_data <= nxt_timer;
            end
        end
    end

    //======================================================================
    // cycle monitor
    assign rx_load    = rx_cyc_start_valid && !is_master;
    assign started_ev = (is_master && tx_cyc_start_sent)
                     || (!is_master && rx_cyc_start_valid);
    // a new tick while still waiting means the last start went missing
    assign lost_ev    = !is_master && nxt_tick && expect_ff
                     && !rx_cyc_start_valid;
    assign done_ev    = iso_cycle_end && in_cycle_ff;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            expect_ff   <= 1'b0;
            in_cycle_ff <= 1'b0;
        end else if (core_ce) begin
            if (is_master || rx_cyc_start_valid) begin
                expect_ff <= 1'b0;
            end else if (nxt_tick) begin
                expect_ff <= 1'b1;
            end
            if (started_ev) begin
                in_cycle_ff <= 1'b1;
            end else if (iso_cycle_end) begin
                in_cycle_ff <= 1'b0;
            end
        end
    end

    //======================================================================
    // host port handshake
    assign host_acc = (host_st_ff == ICTM_IDLE) && !cs_n_s;
    assign host_wr  = host_acc && !wr_n_s;
    assign wr_timer = host_wr && (addr_s == ICTM_REG_CYCLE_TIME);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            host_st_ff    <= ICTM_IDLE;
            host_ack_n    <= 1'b1;
            host_data_oe  <= 1'b0;
            host_data_out <= 32'h0000_0000;
        end else if (core_ce) begin
            unique case (host_st_ff)
                ICTM_IDLE: begin
                    if (!cs_n_s) begin
                        host_st_ff   <= ICTM_HOLD;
                        host_ack_n   <= 1'b0;
                        host_data_oe <= wr_n_s;
                        unique case (addr_s)
                            ICTM_REG_CTRL:
                                host_data_out <= {29'h0, ctrl_ff};
                            ICTM_REG_FLAGS:
                                host_data_out <= {29'h0, cycle_done_flag,
                                                  cycle_lost_flag,
                                                  cycle_started_flag};
                            ICTM_REG_CYCLE_TIME:
                                host_data_out <= timer_ff;
                            default:
                                host_data_out <= 32'h0000_0000;
                        endcase
                    end
                end
                ICTM_HOLD: begin
                    // hold the answer until the host drops its strobe
                    if (cs_n_s) begin
                        host_st_ff   <= ICTM_IDLE;
                        host_ack_n   <= 1'b1;
                        host_data_oe <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_ff <= ICTM_CTRL_RESET;
        end else if (core_ce && host_wr && addr_s == ICTM_REG_CTRL) begin
            ctrl_ff <= wdata_s[2:0];
        end
    end

    //======================================================================
    // sticky flags, set wins over a clear in the same cycle
    assign flg_set = {done_ev, lost_ev, started_ev};
    assign flg_clr = (host_wr && addr_s == ICTM_REG_FLAGS) ? wdata_s[2:0]
                                                           : 3'h0;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            {cycle_done_flag, cycle_lost_flag, cycle_started_flag}
                <= ICTM_FLG_RESET;
        end else if (core_ce) begin
            cycle_started_flag <= flg_set[ICTM_FLG_STARTED]
                || (cycle_started_flag && !flg_clr[ICTM_FLG_STARTED]);
            cycle_lost_flag    <= flg_set[ICTM_FLG_LOST]
                || (cycle_lost_flag && !flg_clr[ICTM_FLG_LOST]);
            cycle_done_flag    <= flg_set[ICTM_FLG_DONE]
                || (cycle_done_flag && !flg_clr[ICTM_FLG_DONE]);
        end
    end

    //======================================================================
    // serial-bus register space read
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            csr_rd_valid <= 1'b0;
            csr_rd_hit   <= 1'b0;
            csr_rd_data  <= 32'h0000_0000;
        end else if (core_ce) begin
            csr_rd_valid <= csr_rd_req;
            csr_rd_hit   <= csr_rd_req
                         && (csr_rd_addr == ICTM_CSR_CYCLE_TIME);
            if (csr_rd_req) begin
                csr_rd_data <= (csr_rd_addr == ICTM_CSR_CYCLE_TIME)
                             ? timer_ff : 32'h0000_0000;
            end
        end
    end

endmodule

// [verif/ictm_cycle_timer_checker.sv]
`timescale 1ns/10ps
//==========================================================================
// port checker of the cycle timer
module ictm_cycle_timer_checker
    import ictm_pkg::*;
(
    input wire logic        core_clk,           // clock
    input wire logic        reset_n,            // reset
    input wire logic        host_cs_n,          // strobe
    input wire logic        host_ack_n,         // complete
    input wire logic        host_data_oe,       // drive
    input wire logic        cycle_tick_out,     // tick
    input wire logic        tx_cyc_start_req,   // send
    input wire logic [31:0] tx_cyc_start_data,  // quadlet
    input wire logic        csr_rd_req,         // read
    input wire logic [11:0] csr_rd_addr,        // offset
    input wire logic        csr_rd_valid,       // answer
    input wire logic        csr_rd_hit,         // hit
    input wire logic [31:0] csr_rd_data,        // data
    input wire logic        iso_cycle_end,      // cycle over
    input wire logic        cycle_started_flag, // started
    input wire logic        cycle_lost_flag,    // lost
    input wire logic        cycle_done_flag     // done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    //======================================================================
    // host handshake and serial-bus register space reads
    sequence s_cs_low;
        !host_cs_n [*3];
    endsequence
    sequence s_cs_high;
        host_cs_n [*4];
    endsequence
    a_ack_answer: assert property (
        s_cs_low |-> ##[0:1] !host_ack_n)
        else $error("no ack to a held strobe");
    a_ack_release: assert property (
        s_cs_high |-> host_ack_n && !host_data_oe)
        else $error("ack or drive held after strobe rose");
    a_oe_with_ack: assert property (
        host_data_oe |-> !host_ack_n)
        else $error("data driven without ack");
    a_csr_answer: assert property (
        csr_rd_req |=> csr_rd_valid &&
            csr_rd_hit == ($past(csr_rd_addr) == ICTM_CSR_CYCLE_TIME))
        else $error("serial-bus read answered wrongly");
    a_csr_miss_zero: assert property (
        csr_rd_valid && !csr_rd_hit |-> csr_rd_data == 32'h0000_0000)
        else $error("missed serial-bus read gave data");

    //======================================================================
    // cycle tick and monitor
    a_tick_single: assert property (
        cycle_tick_out |=> !cycle_tick_out)
        else $error("tick longer than one cycle");
    a_req_on_tick: assert property (
        tx_cyc_start_req |-> cycle_tick_out &&
            tx_cyc_start_data[11:0] == 12'h000)
        else $error("cycle-start request off a tick");
    a_lost_on_tick: assert property (
        $rose(cycle_lost_flag) |-> cycle_tick_out)
        else $error("lost flag set off a tick");
    a_done_cause: assert property (
        $rose(cycle_done_flag) |-> $past(iso_cycle_end))
        else $error("done flag without cycle end");
    a_started_sticky: assert property (
        $fell(cycle_started_flag) |-> $fell(host_ack_n))
        else $error("started flag dropped without a clear");
endmodule

bind ictm_cycle_timer ictm_cycle_timer_checker chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .host_cs_n(host_cs_n),
    .host_ack_n(host_ack_n), .host_data_oe(host_data_oe),
    .cycle_tick_out(cycle_tick_out), .tx_cyc_start_req(tx_cyc_start_req),
    .tx_cyc_start_data(tx_cyc_start_data), .csr_rd_req(csr_rd_req),
    .csr_rd_addr(csr_rd_addr), .csr_rd_valid(csr_rd_valid),
    .csr_rd_hit(csr_rd_hit), .csr_rd_data(csr_rd_data),
    .iso_cycle_end(iso_cycle_end), .cycle_started_flag(cycle_started_flag),
    .cycle_lost_flag(cycle_lost_flag), .cycle_done_flag(cycle_done_flag));

// [verif/ictm_phy_model.sv]
`timescale 1ns/10ps
//==========================================================================
// phy clock and transmitter stand-in
module ictm_phy_model (
    input  wire logic core_clk,         // core clock
    input  wire logic reset_n,          // synchronous reset
    input  wire logic slow,             // answer late
    input  wire logic tx_cyc_start_req, // send request
    output logic      phy_sclk,         // 49.152 MHz clock
    output logic      tx_cyc_start_sent // packet went out
);
    int wait_q;

    // the phy system clock runs free, unrelated to core_clk
    initial begin
        phy_sclk = 1'b0;
        forever #10.17 phy_sclk = ~phy_sclk;
    end

    always @(posedge core_clk) begin
        tx_cyc_start_sent <= 1'b0;
        if (!reset_n) begin
            wait_q <= 0;
        end else if (tx_cyc_start_req) begin
            wait_q <= slow ? 6 : 1;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
            tx_cyc_start_sent <= (wait_q == 1);
        end
    end
endmodule

// [verif/ictm_cycle_timer_tb.sv]
`timescale 1ns/10ps
//==========================================================================
// self-checking bench of the cycle timer
module ictm_cycle_timer_tb
    import ictm_pkg::*;
;
    logic        core_clk = 1'b0, reset_n = 1'b0, slow = 1'b0;
    logic        host_cs_n = 1'b1, host_wr_n = 1'b1;
    logic [7:0]  host_addr = 8'h00;
    logic [31:0] host_data_in = 32'h0, host_data_out, rd, t0, tx_seen;
    logic        host_data_oe, host_ack_n, phy_sclk, seen, req_seen;
    logic        ext_cycle_tick_in = 1'b1;
    logic        rx_cyc_start_valid = 1'b0, iso_cycle_end = 1'b0;
    logic [31:0] rx_cyc_start_data = 32'h0, csr_rd_data, tx_cyc_start_data;
    logic        csr_rd_req = 1'b0, csr_rd_valid, csr_rd_hit;
    logic [11:0] csr_rd_addr = 12'h000;
    logic        cycle_tick_out, tx_cyc_start_req, tx_cyc_start_sent;
    logic        cycle_started_flag, cycle_lost_flag, cycle_done_flag;
    int          fails = 0, n_checks = 0;

    //======================================================================
    // rows: write bit, address, write data or expected read
    localparam logic [10:0] R_W = 11'h150;
    localparam logic [7:0]  R_A [11] = '{8'h14, 8'h08, 8'h0C, 8'h20, 8'h20,
        8'h20, 8'h14, 8'h14, 8'h08, 8'h08, 8'h14};
    localparam logic [31:0] R_D [11] = '{32'h0, 32'h0, 32'h0, 32'h0,
        32'hDEADBEEF, 32'h0, 32'h12345678, 32'h12345678, 32'h6, 32'h6,
        32'h12345678};

    initial forever #2.5 core_clk = ~core_clk;

    ictm_cycle_timer dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .core_ce(1'b1),
        .host_cs_n(host_cs_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .host_ack_n(host_ack_n),
        .phy_sclk(phy_sclk), .ext_cycle_tick_in(ext_cycle_tick_in),
        .cycle_tick_out(cycle_tick_out),
        .rx_cyc_start_valid(rx_cyc_start_valid),
        .rx_cyc_start_data(rx_cyc_start_data), .iso_cycle_end(iso_cycle_end),
        .csr_rd_req(csr_rd_req), .csr_rd_addr(csr_rd_addr),
        .csr_rd_valid(csr_rd_valid), .csr_rd_hit(csr_rd_hit),
        .csr_rd_data(csr_rd_data), .tx_cyc_start_req(tx_cyc_start_req),
        .tx_cyc_start_data(tx_cyc_start_data),
        .tx_cyc_start_sent(tx_cyc_start_sent),
        .cycle_started_flag(cycle_started_flag),
        .cycle_lost_flag(cycle_lost_flag), .cycle_done_flag(cycle_done_flag));

    ictm_phy_model model_u (
        .core_clk(core_clk), .reset_n(reset_n), .slow(slow),
        .tx_cyc_start_req(tx_cyc_start_req), .phy_sclk(phy_sclk),
        .tx_cyc_start_sent(tx_cyc_start_sent));

    //======================================================================
    // tasks
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h", $time, msg, got);
        end
    endtask

    task automatic done_test(input string s);
        $display("test %s finished", s);
    endtask

    task automatic wait_ack(input logic lvl);
        int k;
        for (k = 0; k < 20 && host_ack_n !== lvl; k++) @(negedge core_clk);
        if (k == 20) begin
            fails++;
            report_and_stop();
        end
    endtask

    // strobe and qualifiers hold until the ack has been seen
    task automatic host(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(negedge core_clk);
        host_cs_n = 1'b0;
        host_wr_n = ~w;
        host_addr = a;
        host_data_in = d;
        wait_ack(1'b0);
        rd = host_data_out;
        host_cs_n = 1'b1;
        wait_ack(1'b1);
    endtask

    task automatic wait_tick(input int lim, input logic must);
        seen = 1'b0;
        for (int k = 0; k < lim && seen !== 1'b1; k++) begin
            @(negedge core_clk);
            seen = cycle_tick_out;
            req_seen = tx_cyc_start_req;
            tx_seen = tx_cyc_start_data;
        end
        if (must && seen !== 1'b1) begin
            fails++;
            report_and_stop();
        end
    endtask

    task automatic ext_pulse();
        @(negedge core_clk);
        ext_cycle_tick_in = 1'b0;
        repeat (4) @(negedge core_clk);
        ext_cycle_tick_in = 1'b1;
    endtask

    task automatic rx_pulse(input logic [31:0] d);
        @(negedge core_clk);
        rx_cyc_start_data = d;
        rx_cyc_start_valid = 1'b1;
        @(negedge core_clk);
        rx_cyc_start_valid = 1'b0;
        @(negedge core_clk);
    endtask

    //======================================================================
    // main sequence
    initial begin
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 11; i++) begin
            host(R_W[i], R_A[i], R_D[i]);
            if (!R_W[i]) chk(rd, R_D[i], "row read");
        end
        done_test("rows");
        host(1'b1, 8'h14, {7'h7F, 13'h1F3F, 12'hBF0});
        host(1'b1, 8'h08, 32'h1);
        wait_tick(400, 1'b1);
        host(1'b0, 8'h14, 32'h0);
        chk(rd[31:12], 32'h0, "wrap of all fields");
        chk(32'(rd[11:0] < 12'h100), 32'h1, "offset restart");
        done_test("internal wrap");
        rx_pulse({7'h05, 13'h0100, 12'hBF8});
        chk(cycle_started_flag, 32'h1, "started on receive");
        host(1'b0, 8'h14, 32'h0);
        chk(rd[31:12], {7'h05, 13'h0100}, "load from packet");
        @(negedge core_clk);
        iso_cycle_end = 1'b1;
        @(negedge core_clk);
        iso_cycle_end = 1'b0;
        @(negedge core_clk);
        chk(cycle_done_flag, 32'h1, "done after cycle end");
        wait_tick(400, 1'b1);
        chk(cycle_lost_flag, 32'h0, "lost too early");
        chk(req_seen, 32'h0, "request as non-master");
        host(1'b1, 8'h14, {7'h05, 13'h0100, 12'hBF0});
        wait_tick(400, 1'b1);
        chk(cycle_lost_flag, 32'h1, "lost on second tick");
        host(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h7, "flags set");
        host(1'b1, 8'h0C, 32'h7);
        host(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0, "flags cleared");
        done_test("monitor");
        for (int i = 0; i < 2; i++) begin
            @(negedge core_clk);
            csr_rd_addr = i ? 12'h204 : 12'h200;
            csr_rd_req = 1'b1;
            @(negedge core_clk);
            csr_rd_req = 1'b0;
            chk(csr_rd_hit, i ? 32'h0 : 32'h1, "register space hit");
            chk(csr_rd_data[31:25], i ? 32'h0 : 32'h5, "space data");
        end
        done_test("register space");
        host(1'b1, 8'h08, 32'h3);
        host(1'b1, 8'h14, 32'h0000_0BF0);
        slow = 1'b1;
        wait_tick(400, 1'b1);
        chk(req_seen, 32'h1, "request on tick");
        chk(tx_seen, 32'h0000_1000, "sent quadlet");
        repeat (10) @(negedge core_clk);
        chk(cycle_started_flag, 32'h1, "started on send");
        rx_pulse(32'hFE00_0000);
        host(1'b0, 8'h14, 32'h0);
        chk(rd[31:25], 32'h0, "master ignores packet");
        done_test("master");
        host(1'b1, 8'h08, 32'h7);
        host(1'b0, 8'h14, 32'h0);
        t0 = rd;
        ext_pulse();
        wait_tick(40, 1'b1);
        host(1'b0, 8'h14, 32'h0);
        chk(rd[24:12], t0[24:12] + 13'h1, "external count");
        chk(32'(rd[11:0] < 12'h40), 32'h1, "external offset");
        host(1'b1, 8'h08, 32'h6);
        ext_pulse();
        wait_tick(40, 1'b0);
        chk(seen, 32'h0, "stopped timer ticked");
        done_test("external");
        @(negedge core_clk);
        reset_n = 1'b0;
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        host(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0, "control after reset");
        host(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0, "timer after reset");
        done_test("reset");
        report_and_stop();
    end
endmodule
